// >>> include/preset_speed_pkg.sv
/*
 * Constants and carrier types for the preset-speed mode selector.
 * Assumes a single 50 MHz core clock and a 32-bit classic Wishbone slave port.
 */
package preset_speed_pkg;

    // ==============================
    // Clock and timing
    localparam int unsigned CLK_MHZ           = 50;
    localparam int unsigned SAMPLE_PERIOD_US  = 1000;
    localparam int unsigned SAMPLE_CYCLES     = SAMPLE_PERIOD_US * CLK_MHZ;
    localparam int unsigned RAMP_UNIT_US      = 1000;
    localparam int unsigned RAMP_CYCLES_PER_MS = RAMP_UNIT_US * CLK_MHZ;
    localparam int unsigned INPUT_READ_MAX_MS = 2;

    // ==============================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PRESET1 = 8'h04;
    localparam logic [7:0] OFS_PRESET2 = 8'h08;
    localparam logic [7:0] OFS_PRESET3 = 8'h0c;
    localparam logic [7:0] OFS_ACCEL   = 8'h10;
    localparam logic [7:0] OFS_DECEL   = 8'h14;
    localparam logic [7:0] OFS_MAX_RPM = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;

    // ==============================
    // Field positions and limits
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_ALLOC_BIT  = 4;
    localparam int unsigned CTRL_SWASG_BIT  = 5;
    localparam int unsigned VALUE_W         = 14;
    localparam logic [13:0] VALUE_MAX       = 14'd10000;
    localparam logic [3:0]  MODE_PRESET     = 4'h3;
    localparam logic [3:0]  MODE_P_SPEED    = 4'h4;
    localparam logic [3:0]  MODE_P_POSITION = 4'h5;
    localparam logic [3:0]  MODE_P_TORQUE   = 4'h6;

    // ==============================
    // Reset values
    localparam logic [3:0]  RST_MODE    = MODE_PRESET;
    localparam logic [13:0] RST_PRESET  = 14'h0000;
    localparam logic [13:0] RST_TIME    = 14'h0000;
    localparam logic [13:0] RST_MAX_RPM = VALUE_MAX;

    // ==============================
    // Types
    typedef enum logic [2:0] {
        SUB_IDLE,
        SUB_PRESET,
        SUB_SPEED,
        SUB_POSITION,
        SUB_TORQUE
    } sub_mode_e;

    typedef struct packed {
        logic sel_a;
        logic sel_b;
        logic dir;
        logic mode_sw;
        logic lock;
    } inputs_s;

    typedef struct packed {
        logic [3:0] mode;
        logic       alloc_user;
        logic       sw_assigned;
    } ctrl_s;

    typedef struct packed {
        ctrl_s                ctrl;
        logic [2:0][13:0]     preset;
        logic [13:0]          accel;
        logic [13:0]          decel;
        logic [13:0]          max_rpm;
        inputs_s              inp;
        logic [31:0]          tick;
        logic [31:0]          acc;
        logic signed [15:0]   speed;
        logic signed [15:0]   torque;
        logic                 torque_mode;
        sub_mode_e            active;
        logic                 complete;
        logic                 pulse_ok;
        logic                 lock_out;
        logic                 ack;
        logic [31:0]          rdata;
    } state_s;

endpackage

// >>> core/preset_speed_mode_select.sv
/*
 * Preset-speed mode selector: decodes speed-select inputs, picks the
 * active control mode, ramps the speed command and drives the
 * positioning-complete pin. Registers over classic Wishbone.
 * Assumes inputs synchronous to core_clk; analog values already digitised.
 */
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - Mode 3 preset only; 4,5,6 combined
// - Presets hold 0 to 10000 rpm
// - Separate accel/decel times 0 to 10000 ms
// - Preset above maximum speed uses maximum
// - Select decode: 00 stop,01 p1,10 p3,11 p2
// - Default allocation: both off selects second mode
// - User allocation: mode switch input chooses mode
// - Inputs acted on within two milliseconds
// - Stop commands zero speed without lock
// - Preset only ignores analog and pulses
// - Mode 4 follows analog speed when stopped
// - Mode 5 stops, completes, then accepts pulses
// - Speed modes show speed compare on pin
// - Mode 6 follows analog torque when stopped
// - Direction input sets preset rotation sense
// - Stop decelerates using deceleration time
module preset_speed_mode_select
    import preset_speed_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC  = SAMPLE_CYCLES,
    parameter int unsigned RAMP_CYC    = RAMP_CYCLES_PER_MS,
    parameter logic [15:0] CMP_WINDOW  = 16'd10
)(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic                    wb_ack_o,
    output logic [31:0]             wb_dat_o,
    // Discrete inputs from host
    input  wire logic               speed_select_a,
    input  wire logic               speed_select_b,
    input  wire logic               rotation_direction_in,
    input  wire logic               mode_switch_in,
    input  wire logic               position_lock_in,
    input  wire logic               pulse_in,
    // Digitised analog commands
    input  wire logic signed [15:0] analog_speed_cmd,
    input  wire logic signed [15:0] analog_torque_cmd,
    // Drive outputs
    output logic signed [15:0]      speed_cmd,
    output logic signed [15:0]      torque_cmd,
    output logic                    torque_mode,
    output logic                    position_hold,
    output logic                    pulse_accept,
    output logic                    positioning_complete_out,
    output logic [2:0]              active_mode
);

    // ==============================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [13:0] clamp_val(input logic [31:0] v);
        if (v > {18'h0, VALUE_MAX})
        begin
            return VALUE_MAX;
        end
        return v[13:0];
    endfunction

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return (v < 0) ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic signed [15:0] limit(input logic signed [15:0] v, input logic [13:0] m);
        logic signed [15:0] lim;
        lim = signed'({2'b00, m});
        if (v > lim)
        begin
            return lim;
        end
        if (v < -lim)
        begin
            return 16'(-lim);
        end
        return v;
    endfunction

    state_s cur;
    state_s nxt;

    // ==============================
    // Combinational next state
    logic               stop_sel;
    logic               second;
    logic [13:0]        preset_mag;
    logic signed [15:0] target;
    logic [13:0]        ramp_time;
    logic [31:0]        ramp_limit;
    logic [31:0]        acc_sum;
    logic               req;
    logic [31:0]        reg_old;
    logic [31:0]        reg_new;
    logic [15:0]        err;

    always_comb
    begin
        nxt = cur;
        stop_sel   = 1'b0;
        second     = 1'b0;
        preset_mag = '0;
        target     = (cur.active == SUB_SPEED) ? limit(analog_speed_cmd, cur.max_rpm) : 16'sd0;
        ramp_time  = '0;
        ramp_limit = '0;
        acc_sum    = '0;
        reg_old    = '0;
        reg_new    = '0;
        err        = '0;
        req        = wb_cyc_i && wb_stb_i && !cur.ack;

        // ==============================
        // Input sampling once per period bounds latency
        if (cur.tick >= SAMPLE_CYC - 1)
        begin
            nxt.tick = '0;
            nxt.inp  = '{speed_select_a, speed_select_b, rotation_direction_in,
                         mode_switch_in, position_lock_in};
        end
        else
        begin
            nxt.tick = cur.tick + 32'd1;
        end

        // ==============================
        // Mode selection
        stop_sel = !cur.inp.sel_a && !cur.inp.sel_b;
        if (cur.ctrl.alloc_user)
        begin
            second = cur.ctrl.sw_assigned && cur.inp.mode_sw;
        end
        else
        begin
            second = stop_sel;
        end
        unique case (cur.ctrl.mode)
            MODE_PRESET:     nxt.active = SUB_PRESET;
            MODE_P_SPEED:    nxt.active = second ? SUB_SPEED : SUB_PRESET;
            MODE_P_POSITION: nxt.active = second ? SUB_POSITION : SUB_PRESET;
            MODE_P_TORQUE:   nxt.active = second ? SUB_TORQUE : SUB_PRESET;
            default:         nxt.active = SUB_IDLE;
        endcase

        // ==============================
        // Preset decode and target
        unique case ({cur.inp.sel_a, cur.inp.sel_b})
            2'b01:   preset_mag = cur.preset[0];
            2'b10:   preset_mag = cur.preset[2];
            2'b11:   preset_mag = cur.preset[1];
            default: preset_mag = '0;
        endcase
        if (preset_mag > cur.max_rpm)
        begin
            preset_mag = cur.max_rpm;
        end
        if (cur.active == SUB_PRESET)
        begin
            target = cur.inp.dir ? 16'(-signed'({2'b00, preset_mag}))
                                 : signed'({2'b00, preset_mag});
        end

        // ==============================
        // Speed command
        nxt.torque_mode = (cur.active == SUB_TORQUE);
        nxt.torque      = (cur.active == SUB_TORQUE) ? analog_torque_cmd : 16'sd0;
        if (cur.active == SUB_SPEED)
        begin
            nxt.speed = limit(analog_speed_cmd, cur.max_rpm);
            nxt.acc   = '0;
        end
        else if (cur.active == SUB_TORQUE || cur.active == SUB_IDLE)
        begin
            nxt.speed = '0;
            nxt.acc   = '0;
        end
        else if (cur.speed != target)
        begin
            // Speeding up when at rest, or same sign and larger magnitude
            if (cur.speed == 0 || ((cur.speed < 0) == (target < 0) && mag(target) > mag(cur.speed)))
            begin
                ramp_time = cur.accel;
            end
            else
            begin
                ramp_time = cur.decel;
            end
            // Full-scale change takes ramp_time; zero jumps straight to target, else at most one rpm step per cycle
            ramp_limit = 32'(ramp_time) * RAMP_CYC;
            acc_sum    = cur.acc + 32'(cur.max_rpm);
            if (ramp_time == '0)
            begin
                nxt.speed = target;
                nxt.acc   = '0;
            end
            else if (acc_sum >= ramp_limit)
            begin
                nxt.speed = (target > cur.speed) ? cur.speed + 16'sd1 : cur.speed - 16'sd1;
                nxt.acc   = acc_sum - ramp_limit;
            end
            else
            begin
                nxt.acc = acc_sum;
            end
        end
        else
        begin
            nxt.acc = '0;
        end

        // ==============================
        // Completion pin and pulse gate
        err = mag(16'(cur.speed - target));
        if (cur.active == SUB_POSITION)
        begin
            nxt.complete = (cur.speed == 0);
        end
        else if (cur.active == SUB_IDLE || cur.active == SUB_TORQUE || nxt.active == SUB_POSITION)
        begin
            nxt.complete = 1'b0;
        end
        else
        begin
            nxt.complete = (err <= CMP_WINDOW);
        end
        // Pulses dropped until hold is reached, host waits for it unless rude
        nxt.pulse_ok = pulse_in && cur.active == SUB_POSITION && cur.complete;
        nxt.lock_out = (cur.active == SUB_POSITION && cur.complete)
                    || (cur.active == SUB_PRESET && stop_sel && cur.inp.lock);

        // ==============================
        // Register access, one cycle to ack
        nxt.ack   = req;
        nxt.rdata = '0;
        if (req)
        begin
            unique case (wb_adr_i)
                OFS_CTRL:    reg_old = {26'h0, cur.ctrl.sw_assigned, cur.ctrl.alloc_user, cur.ctrl.mode};
                OFS_PRESET1: reg_old = {18'h0, cur.preset[0]};
                OFS_PRESET2: reg_old = {18'h0, cur.preset[1]};
                OFS_PRESET3: reg_old = {18'h0, cur.preset[2]};
                OFS_ACCEL:   reg_old = {18'h0, cur.accel};
                OFS_DECEL:   reg_old = {18'h0, cur.decel};
                OFS_MAX_RPM: reg_old = {18'h0, cur.max_rpm};
                OFS_STATUS:  reg_old = {cur.speed, 5'h0, cur.inp, cur.complete, 2'b00, cur.active};
                default:     reg_old = '0;
            endcase
            nxt.rdata = wb_we_i ? 32'h0 : reg_old;
            reg_new   = merge(reg_old, wb_dat_i, wb_sel_i);
            if (wb_we_i)
            begin
                unique case (wb_adr_i)
                    OFS_CTRL:
                    begin
                        nxt.ctrl.mode        = reg_new[CTRL_MODE_LSB +: 4];
                        nxt.ctrl.alloc_user  = reg_new[CTRL_ALLOC_BIT];
                        nxt.ctrl.sw_assigned = reg_new[CTRL_SWASG_BIT];
                    end
                    OFS_PRESET1: nxt.preset[0] = clamp_val(reg_new);
                    OFS_PRESET2: nxt.preset[1] = clamp_val(reg_new);
                    OFS_PRESET3: nxt.preset[2] = clamp_val(reg_new);
                    OFS_ACCEL:   nxt.accel     = clamp_val(reg_new);
                    OFS_DECEL:   nxt.decel     = clamp_val(reg_new);
                    OFS_MAX_RPM: nxt.max_rpm   = clamp_val(reg_new);
                    default:     nxt.ctrl      = cur.ctrl;
                endcase
            end
        end
    end

    // ==============================
    // State register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cur               <= '0;
            cur.ctrl.mode     <= RST_MODE;
            cur.preset        <= {3{RST_PRESET}};
            cur.accel         <= RST_TIME;
            cur.decel         <= RST_TIME;
            cur.max_rpm       <= RST_MAX_RPM;
            cur.active        <= SUB_PRESET;
        end
        else
        begin
            cur <= nxt;
        end
    end

    // ==============================
    // Outputs straight from state
    assign wb_ack_o                 = cur.ack;
    assign wb_dat_o                 = cur.rdata;
    assign speed_cmd                = cur.speed;
    assign torque_cmd               = cur.torque;
    assign torque_mode              = cur.torque_mode;
    assign position_hold            = cur.lock_out;
    assign pulse_accept             = cur.pulse_ok;
    assign positioning_complete_out = cur.complete;
    assign active_mode              = cur.active;

endmodule

// >>> bench/preset_speed_props.sv
/* Port checker for the preset-speed selector.
   Assumes the top module's ports; bound after the module. */
`timescale 1ns/1ps
module preset_speed_props (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               nrst,
    // Bus
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    // Drive side
    input wire logic               pulse_in,
    input wire logic signed [15:0] speed_cmd,
    input wire logic signed [15:0] torque_cmd,
    input wire logic               torque_mode,
    input wire logic               pulse_accept,
    input wire logic               positioning_complete_out,
    input wire logic [2:0]         active_mode
);
default clocking dc @(posedge core_clk);
endclocking
default disable iff (!nrst);
// ==============================
// Bus steps
sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
sequence ack_seen;
    wb_ack_o ##1 !wb_ack_o;
endsequence
ack_resp_a: assert property (wb_req |=> ack_seen) else $error("ack missing");
ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
// ==============================
// Control modes
rst_state_a: assert property (disable iff (1'b0) !nrst |=> active_mode == 3'h1 && speed_cmd == 16'sh0)
    else $error("reset state");
spd_limit_a: assert property (speed_cmd <= 16'sd10000 && speed_cmd >= -16'sd10000) else $error("speed range");
preset_quiet_a: assert property (active_mode == 3'h1 && $past(active_mode) == 3'h1 |->
    !pulse_accept && torque_cmd == 16'sh0) else $error("preset not quiet");
pulse_src_a: assert property (pulse_accept |-> $past(pulse_in)) else $error("pulse out of nowhere");
hold_zero_a: assert property (active_mode == 3'h3 && positioning_complete_out |-> speed_cmd == 16'sh0)
    else $error("hold not at rest");
torque_run_a: assert property (torque_mode && $past(torque_mode) |-> speed_cmd == 16'sh0 &&
    !positioning_complete_out) else $error("torque mode speed");
torque_off_a: assert property (!torque_mode |-> torque_cmd == 16'sh0) else $error("torque leak");
endmodule
bind preset_speed_mode_select preset_speed_props preset_speed_props_i (.core_clk(core_clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pulse_in(pulse_in),
    .speed_cmd(speed_cmd), .torque_cmd(torque_cmd), .torque_mode(torque_mode), .pulse_accept(pulse_accept),
    .positioning_complete_out(positioning_complete_out), .active_mode(active_mode));

// >>> bench/host_model.sv
/* Host controller model driving select lines and position pulses.
   Assumes the bench states wishes; politeness can be switched off. */
`timescale 1ns/1ps
module host_model (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // Bench wishes
    input wire logic [1:0] want_sel,
    input wire logic       want_pulse,
    input wire logic       rude,
    // Seen from drive
    input wire logic       pos_mode,
    input wire logic       complete,
    // To drive
    output logic           speed_select_a,
    output logic           speed_select_b,
    output logic           pulse_in
);
// ==============================
// In position mode, reselect preset only once complete, unless rude
always_ff @(posedge core_clk)
begin
    if (!nrst)
    begin
        {speed_select_a, speed_select_b, pulse_in} <= 3'h0;
    end
    else
    begin
        if (!pos_mode || complete || rude)
        begin
            {speed_select_a, speed_select_b} <= want_sel;
        end
        pulse_in <= want_pulse && (rude || (pos_mode && complete));
    end
end
endmodule

// >>> bench/tb_top.sv
/* Self-checking bench for the preset-speed selector.
   Assumes shortened sample and ramp counts; host model on the select lines. */
`timescale 1ns/1ps
module tb_top;
import preset_speed_pkg::*;
localparam int SC = 8;
localparam int LAT = 2 * SC + 2;
typedef struct packed {logic [1:0] sel; logic dir; logic signed [15:0] spd;} row_s;
logic core_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, dir = 0, msw = 0;
logic want_pulse = 0, rude = 0, lck = 0, sa, sb, pin, ack, tmode, hold, pacc, cpl;
logic [1:0] want_sel = 2'h0;
logic [7:0] adr = 8'h00;
logic [31:0] dat = 32'h0, q, rd;
logic signed [15:0] aspd = 16'sd555, atrq = 16'sd77, spd, trq;
logic [2:0] am;
int errors = 0, cmp_count = 0, n;
row_s rows [6] = '{'{2'h0, 0, 16'sd0}, '{2'h1, 0, 16'sd100}, '{2'h2, 0, 16'sd250},
    '{2'h3, 0, 16'sd200}, '{2'h1, 1, -16'sd100}, '{2'h2, 1, -16'sd250}};
initial forever #10 core_clk = ~core_clk;
preset_speed_mode_select #(.SAMPLE_CYC(SC), .RAMP_CYC(4)) preset_speed_mode_select_i (
    .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(q), .speed_select_a(sa),
    .speed_select_b(sb), .rotation_direction_in(dir), .mode_switch_in(msw), .position_lock_in(lck),
    .pulse_in(pin), .analog_speed_cmd(aspd), .analog_torque_cmd(atrq), .speed_cmd(spd),
    .torque_cmd(trq), .torque_mode(tmode), .position_hold(hold), .pulse_accept(pacc),
    .positioning_complete_out(cpl), .active_mode(am));
host_model host_model_i (.core_clk(core_clk), .nrst(nrst), .want_sel(want_sel), .want_pulse(want_pulse),
    .rude(rude), .pos_mode(am == 3'h3), .complete(cpl), .speed_select_a(sa), .speed_select_b(sb),
    .pulse_in(pin));
// ==============================
// Shared tasks
task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
        $display("[ERR] %s exp %h got %h", nm, e, g);
        errors++;
    end
endtask
// Request held until ack is seen high at a rising edge
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    k = 0;
    do
    begin
        @(posedge core_clk);
        k++;
    end
    while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1)
    begin
        errors++;
        wrap_up();
    end
    rd = q;
    {cyc, stb} <= 2'b00;
endtask
// Ends on a rising edge, so the next stimulus lands there
task automatic settle();
    repeat (LAT) @(posedge core_clk);
endtask
// ==============================
// Main sequence
initial
begin
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    @(negedge core_clk);
    chk("reset mode", 3'h1, am);
    wb(0, OFS_CTRL, 0);
    chk("ctrl reset", 32'h3, rd);
    wb(0, OFS_MAX_RPM, 0);
    chk("max reset", 32'd10000, rd);
    wb(0, 8'h20, 0);
    chk("unmapped", 32'h0, rd);
    wb(1, OFS_PRESET1, 100);
    wb(1, OFS_PRESET2, 200);
    wb(1, OFS_PRESET3, 12000);
    wb(0, OFS_PRESET3, 0);
    chk("preset clamp", 32'd10000, rd);
    wb(1, OFS_MAX_RPM, 250);
    rude <= 1;
    want_pulse <= 1;
    foreach (rows[i])
    begin
        want_sel <= rows[i].sel;
        dir <= rows[i].dir;
        settle();
        chk("row speed", 32'(rows[i].spd), 32'(spd));
        chk("row cmp", 1, cpl);
    end
    {rude, want_pulse, dir} <= 3'b000;
    want_sel <= 2'h0;
    wb(1, OFS_CTRL, 4);
    settle();
    chk("speed mode", 2, am);
    chk("analog", 32'd250, 32'(spd));
    chk("speed cmp", 1, cpl);
    wb(1, OFS_CTRL, 6);
    settle();
    chk("torque", 32'd77, 32'(trq));
    chk("torque flag", 1, tmode);
    wb(1, OFS_PRESET3, 0);
    want_sel <= 2'h2;
    settle();
    chk("servo lock", 1, am);
    chk("lock speed", 0, 32'(spd));
    chk("lock torque", 0, 32'(trq));
    chk("lock flag", 0, tmode);
    wb(1, OFS_CTRL, 32'h34);
    want_sel <= 2'h1;
    settle();
    chk("switch off", 1, am);
    msw <= 1;
    settle();
    chk("switch on", 2, am);
    wb(1, OFS_CTRL, 7);
    settle();
    chk("bad mode", 0, am);
    wb(1, OFS_CTRL, 5);
    wb(1, OFS_DECEL, 2);
    want_sel <= 2'h1;
    settle();
    want_sel <= 2'h0;
    want_pulse <= 1;
    rude <= 1;
    n = 0;
    while (am !== 3'h3 && n < LAT)
    begin
        @(posedge core_clk);
        n++;
    end
    if (am !== 3'h3)
    begin
        errors++;
        wrap_up();
    end
    chk("ramp start", 1, spd != 0);
    chk("pulse ignored", 0, pacc);
    n = 0;
    while (cpl !== 1'b1 && n < 400)
    begin
        @(posedge core_clk);
        n++;
    end
    if (cpl !== 1'b1)
    begin
        errors++;
        wrap_up();
    end
    chk("stopped", 0, 32'(spd));
    wb(0, OFS_STATUS, 0);
    chk("status", 32'h000000a3, rd);
    chk("hold", 1, hold);
    rude <= 0;
    repeat (3) @(posedge core_clk);
    chk("pulse taken", 1, pacc);
    want_pulse <= 0;
    want_sel <= 2'h1;
    settle();
    chk("back to preset", 1, am);
    // Mid-run reset, then stop with lock requested
    nrst <= 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    chk("reset again", 1, am);
    chk("reset speed", 0, 32'(spd));
    wb(0, OFS_CTRL, 0);
    chk("ctrl again", 32'h3, rd);
    want_sel <= 2'h0;
    lck <= 1;
    settle();
    chk("stop lock", 1, hold);
    wrap_up();
end
endmodule
